// file: inc/osc_pkg.sv
package osc_pkg;
	// register map
	localparam logic [3:0] OSC_ADDR_STATUS = 4'h9;
	localparam logic [3:0] OSC_ADDR_PULSE = 4'ha;
	localparam logic [3:0] OSC_ADDR_CHECKSUM = 4'hb;
	// status register fields
	localparam int OSC_BIT_READY = 0;
	localparam int OSC_BIT_MISSED = 1;
	localparam int OSC_BIT_INT_EN = 2;
	localparam int OSC_BIT_UNUSED = 3;
	localparam int OSC_BIT_OVF_PULSE = 4;
	localparam int OSC_BIT_OVF_EN = 5;
	localparam int OSC_BIT_OVERFLOW = 6;
	localparam int OSC_BIT_STANDBY = 7;
	localparam logic [7:0] OSC_STATUS_RESET = 8'h00;
	localparam logic [7:0] OSC_CHECKSUM_RESET = 8'h00;
	// checksum feedback taps
	localparam logic [7:0] OSC_CHK_POLY = 8'h1d;
	// one-shot pulse length in cycles
	localparam int OSC_PULSE_CYCLES = 1;
endpackage : osc_pkg

// file: inc/osc_chk_if.sv
`timescale 1ns/1ns
interface osc_chk_if #(parameter int DW = 16);
	logic burst_strobe;
	logic frame_strobe;
	logic [DW-1:0] i_data;
	logic [DW-1:0] q_data;
	logic sync_fall;
	logic [7:0] checksum;
	modport ctl (output burst_strobe, output frame_strobe, output i_data,
		output q_data, output sync_fall, input checksum);
	modport gen (input burst_strobe, input frame_strobe, input i_data,
		input q_data, input sync_fall, output checksum);
endinterface : osc_chk_if

// file: logic/osc_checksum.sv
`timescale 1ns/1ns
module osc_checksum #(
	parameter int DW = 16
) (
	input wire logic clock_i,
	input wire logic rst_i,
	osc_chk_if.gen chk
);
	// ==========================================
	// non-linear feedback accumulator
	logic [7:0] acc_q;
	logic [7:0] acc_d;
	logic [7:0] fold;
	logic [7:0] hold_q;

	always_comb begin
		fold = 8'h00;
		for (int k = 0; k < DW; k++) begin
			fold[k % 8] = fold[k % 8] ^ chk.i_data[k] ^ chk.q_data[(k + 3) % DW];
		end
		fold[0] = fold[0] ^ chk.burst_strobe;
		fold[1] = fold[1] ^ chk.frame_strobe;
		// and-term makes the feedback non-linear
		acc_d = {acc_q[6:0], 1'b0} ^ fold ^ (acc_q[7] ? osc_pkg::OSC_CHK_POLY : 8'h00)
			^ {7'h00, acc_q[3] & acc_q[5]};
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			acc_q <= osc_pkg::OSC_CHECKSUM_RESET;
			hold_q <= osc_pkg::OSC_CHECKSUM_RESET;
		end else if (chk.sync_fall) begin
			hold_q <= acc_q;
			acc_q <= osc_pkg::OSC_CHECKSUM_RESET;
		end else begin
			acc_q <= acc_d;
		end
	end

	assign chk.checksum = hold_q;

	a_chk_store: assert property (@(posedge clock_i) disable iff (rst_i)
		chk.sync_fall |=> hold_q == $past(acc_q) && acc_q == 8'h00) // see R21
		else $error("checksum not stored on sync fall");
endmodule : osc_checksum

// file: logic/osc_status_regs.sv
`timescale 1ns/1ns
// Function
// R1 - host sets ready bit 0 to arm; device clears it after capture
// R2 - sample arriving while ready is low sets missed bit 1
// R3 - writing zero clears missed; writing one leaves it
// R4 - interrupt enable bit 2 low holds interrupt pin high
// R5 - interrupt enable high makes interrupt pin follow ready
// R6 - pulse select bit 4 low: overflow pin is inverse of overflow flag
// R7 - pulse select and detect enable high: one-cycle low pulse per overflow
// R8 - detect enable bit 5 low: no overflow flag, no low overflow pin
// R9 - overflow while enabled sets sticky bit 6 until host clears
// R10 - writing zero clears overflow flag; writing one has no effect
// R11 - standby bit 7 freezes the block, keeps settings, output data invalid; code gates only capture, stuck, missed and overflow, checksum keeps running
// R12 - host should enable interrupt only after setting ready
// R13 - write 01h sets ready clears missed; 03h sets ready keeps missed
// R14 - capture coinciding with ready write leaves ready high, stuck
// R15 - host should clear ready before setting it again
// R16 - host clears missed on first arming, checks it later
// R17 - missed high while ready high tells host of stuck ready
// R18 - after ready drops host reads captured in-phase and quadrature data
// R19 - any write to address 10 pulses one-shot pin; data ignored
// R20 - eight-bit non-linear checksum of strobes and output bits
// R21 - sync falling stores checksum at address 11 and clears generator
// R22 - one-shot pin active low for one clock after the write
module osc_status_regs #(
	parameter int DW = 16
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic sample_valid_i,
	input wire logic [DW-1:0] i_data_i,
	input wire logic [DW-1:0] q_data_i,
	input wire logic burst_strobe_out_i,
	input wire logic frame_strobe_out_i,
	input wire logic sync_i,
	input wire logic overflow_i,
	output logic [DW-1:0] cap_i_o,
	output logic [DW-1:0] cap_q_o,
	output logic int_n_o,
	output logic ovf_pin_n_o,
	output logic pulse_out_n_o,
	output logic standby_o
);
	// refuse sample widths the capture and checksum paths cannot serve
	if (DW < 1 || DW > 64) begin : g_bad_width
		$error("data width out of range");
	end

	// ==========================================
	// status register bits
	logic ready_q;
	logic missed_q;
	logic int_en_q;
	logic spare_q;
	logic ovf_pulse_sel_q;
	logic ovf_detect_en_q;
	logic overflow_q;
	logic standby_q;
	logic wr_status;
	logic wr_pulse;
	logic capture;
	logic ovf_event;
	logic stuck_q;
	logic arm_clash;

	assign wr_status = wr_i && addr_i == osc_pkg::OSC_ADDR_STATUS;
	assign wr_pulse = wr_i && addr_i == osc_pkg::OSC_ADDR_PULSE;
	// standby freezes capture activity
	assign capture = sample_valid_i && ready_q && !stuck_q && !standby_q; // see R11
	// sample landing on the arming write leaves ready stuck high
	assign arm_clash = sample_valid_i && wr_status && !standby_q
		&& wdata_i[osc_pkg::OSC_BIT_READY];
	assign ovf_event = overflow_i && ovf_detect_en_q && !standby_q; // see R8

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ready_q <= osc_pkg::OSC_STATUS_RESET[osc_pkg::OSC_BIT_READY];
		end else if (wr_status) begin
			// a write wins over a coinciding capture
			ready_q <= wdata_i[osc_pkg::OSC_BIT_READY]; // see R1 see R14
		end else if (capture) begin
			ready_q <= 1'b0; // see R1
		end
	end

	// stuck ready blocks captures until ready is cleared and set again
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			stuck_q <= 1'b0;
		end else if (arm_clash) begin
			stuck_q <= 1'b1; // see R14
		end else if (wr_status && !wdata_i[osc_pkg::OSC_BIT_READY]) begin
			stuck_q <= 1'b0; // see R14
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			missed_q <= osc_pkg::OSC_STATUS_RESET[osc_pkg::OSC_BIT_MISSED];
		end else if (sample_valid_i && !standby_q && (!ready_q || wr_status)) begin
			// a sample during the arming write still counts as missed
			missed_q <= 1'b1; // see R2 see R17
		end else if (wr_status && !wdata_i[osc_pkg::OSC_BIT_MISSED]) begin
			missed_q <= 1'b0; // see R3 see R13
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			int_en_q <= osc_pkg::OSC_STATUS_RESET[osc_pkg::OSC_BIT_INT_EN];
			spare_q <= osc_pkg::OSC_STATUS_RESET[osc_pkg::OSC_BIT_UNUSED];
			ovf_pulse_sel_q <= osc_pkg::OSC_STATUS_RESET[osc_pkg::OSC_BIT_OVF_PULSE];
			ovf_detect_en_q <= osc_pkg::OSC_STATUS_RESET[osc_pkg::OSC_BIT_OVF_EN];
			standby_q <= osc_pkg::OSC_STATUS_RESET[osc_pkg::OSC_BIT_STANDBY];
		end else if (wr_status) begin
			int_en_q <= wdata_i[osc_pkg::OSC_BIT_INT_EN];
			spare_q <= wdata_i[osc_pkg::OSC_BIT_UNUSED];
			ovf_pulse_sel_q <= wdata_i[osc_pkg::OSC_BIT_OVF_PULSE];
			ovf_detect_en_q <= wdata_i[osc_pkg::OSC_BIT_OVF_EN];
			standby_q <= wdata_i[osc_pkg::OSC_BIT_STANDBY]; // see R11
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			overflow_q <= osc_pkg::OSC_STATUS_RESET[osc_pkg::OSC_BIT_OVERFLOW];
		end else if (ovf_event) begin
			overflow_q <= 1'b1; // see R9
		end else if (wr_status && !wdata_i[osc_pkg::OSC_BIT_OVERFLOW]) begin
			overflow_q <= 1'b0; // see R10
		end
	end

	// ==========================================
	// captured sample
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cap_i_o <= '0;
			cap_q_o <= '0;
		end else if (capture) begin
			cap_i_o <= i_data_i; // see R18
			cap_q_o <= q_data_i;
		end
	end

	// ==========================================
	// output pins
	logic ovf_pin_n_q;
	logic pulse_n_q;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ovf_pin_n_q <= 1'b1;
		end else if (!ovf_detect_en_q) begin
			ovf_pin_n_q <= 1'b1; // see R8
		end else if (ovf_pulse_sel_q) begin
			ovf_pin_n_q <= !ovf_event; // see R7
		end else begin
			ovf_pin_n_q <= !(overflow_q || ovf_event); // see R6
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pulse_n_q <= 1'b1;
		end else begin
			pulse_n_q <= !wr_pulse; // see R19 see R22
		end
	end

	assign int_n_o = int_en_q ? ready_q : 1'b1; // see R4 see R5
	assign ovf_pin_n_o = ovf_pin_n_q;
	assign pulse_out_n_o = pulse_n_q;
	assign standby_o = standby_q;

	// ==========================================
	// checksum generator
	osc_chk_if #(.DW(DW)) chk_bus();
	logic sync_q;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sync_q <= 1'b1;
		end else begin
			sync_q <= sync_i;
		end
	end

	assign chk_bus.burst_strobe = burst_strobe_out_i; // see R20
	assign chk_bus.frame_strobe = frame_strobe_out_i;
	assign chk_bus.i_data = i_data_i;
	assign chk_bus.q_data = q_data_i;
	assign chk_bus.sync_fall = sync_q && !sync_i; // see R21

	osc_checksum #(.DW(DW)) u_checksum (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.chk(chk_bus.gen)
	);

	// ==========================================
	// read port
	logic [7:0] status_rd;

	assign status_rd = {standby_q, overflow_q, ovf_detect_en_q,
		ovf_pulse_sel_q, spare_q, int_en_q, missed_q, ready_q};

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				osc_pkg::OSC_ADDR_STATUS: rdata_o <= status_rd;
				osc_pkg::OSC_ADDR_CHECKSUM: rdata_o <= chk_bus.checksum;
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ==========================================
	// checks
	a_ready_capture: assert property (@(posedge clock_i) disable iff (rst_i)
		capture && !wr_status |=> !ready_q) // see R1
		else $error("ready not cleared after capture");
	a_missed_set: assert property (@(posedge clock_i) disable iff (rst_i)
		sample_valid_i && !ready_q && !standby_q |=> missed_q) // see R2
		else $error("missed not set");
	a_missed_keep: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_status && wdata_i[1] && missed_q |=> missed_q) // see R3
		else $error("missed cleared by writing one");
	a_int_off: assert property (@(posedge clock_i) disable iff (rst_i)
		!int_en_q |-> int_n_o) // see R4
		else $error("interrupt low while disabled");
	a_int_follow: assert property (@(posedge clock_i) disable iff (rst_i)
		capture && int_en_q && !wr_status |=> !int_n_o) // see R5
		else $error("interrupt did not drop on capture");
	a_ovf_level: assert property (@(posedge clock_i) disable iff (rst_i)
		ovf_detect_en_q && !ovf_pulse_sel_q && overflow_q
		|=> ovf_detect_en_q |-> !ovf_pin_n_o) // see R6
		else $error("overflow pin not following flag");
	a_ovf_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
		ovf_detect_en_q && ovf_pulse_sel_q && ovf_event && !wr_status
		|=> !ovf_pin_n_o) // see R7
		else $error("overflow pulse missing");
	a_ovf_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
		!ovf_detect_en_q && !overflow_q |=> !overflow_q) // see R8
		else $error("overflow set while detection off");
	a_ovf_pin_off: assert property (@(posedge clock_i) disable iff (rst_i) // see R8
		!ovf_detect_en_q |=> ovf_pin_n_o)
		else $error("overflow pin low while detection off");
	a_stuck_hold: assert property (@(posedge clock_i) disable iff (rst_i) // see R14
		stuck_q && sample_valid_i && !wr_status |=> ready_q)
		else $error("stuck ready cleared by sample");
	a_ovf_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
		overflow_q && !(wr_status && !wdata_i[6]) |=> overflow_q) // see R9
		else $error("overflow flag dropped");
	a_ovf_clear: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_status && !wdata_i[6] && !ovf_event |=> !overflow_q) // see R10
		else $error("overflow not cleared");
	a_arm_write: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_status && wdata_i == 8'h01 && !sample_valid_i
		|=> ready_q && !missed_q) // see R13
		else $error("arming write wrong");
	a_pulse_once: assert property (@(posedge clock_i) disable iff (rst_i) // see R19 see R22
		wr_pulse |=> !pulse_out_n_o ##1 (pulse_out_n_o || $past(wr_pulse)))
		else $error("one-shot pulse wrong");

	c_capture: cover property (@(posedge clock_i) disable iff (rst_i)
		capture);
	c_stuck: cover property (@(posedge clock_i) disable iff (rst_i)
		arm_clash);
	c_ovf_pulse: cover property (@(posedge clock_i) disable iff (rst_i)
		ovf_event && ovf_pulse_sel_q);
	c_sync: cover property (@(posedge clock_i) disable iff (rst_i)
		chk_bus.sync_fall);
endmodule : osc_status_regs

// file: tb/osc_src_model.sv
`timescale 1ns/1ns
// ========================================
// sample and event source facing the block
module osc_src_model (
	input wire logic clock_i,
	output logic sample_valid_o,
	output logic [15:0] i_data_o,
	output logic [15:0] q_data_o,
	output logic burst_strobe_o,
	output logic frame_strobe_o,
	output logic sync_o,
	output logic overflow_o
);
	initial begin
		sample_valid_o = 1'b0;
		i_data_o = 16'h0000;
		q_data_o = 16'hffff;
		burst_strobe_o = 1'b0;
		frame_strobe_o = 1'b0;
		sync_o = 1'b1;
		overflow_o = 1'b0;
	end
	// data lines show the inverse once a sample is gone
	task automatic sample(input logic [15:0] v);
		@(posedge clock_i);
		sample_valid_o <= 1'b1;
		i_data_o <= v;
		q_data_o <= ~v;
		burst_strobe_o <= 1'b1;
		@(posedge clock_i);
		sample_valid_o <= 1'b0;
		i_data_o <= ~v;
		q_data_o <= v;
		burst_strobe_o <= 1'b0;
	endtask : sample
	task automatic ovf();
		@(posedge clock_i);
		overflow_o <= 1'b1;
		@(posedge clock_i);
		overflow_o <= 1'b0;
	endtask : ovf
	task automatic sync_fall();
		@(posedge clock_i);
		sync_o <= 1'b0;
		frame_strobe_o <= ~frame_strobe_o;
		@(posedge clock_i);
		sync_o <= 1'b1;
	endtask : sync_fall
endmodule : osc_src_model

// file: tb/output_status_capture_regs_test.sv
`timescale 1ns/1ns
module output_status_capture_regs_test;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic sv, bs, fs, sy, ov, int_n, ovf_n, pls_n, stby;
	logic [15:0] id, qd, cap_i, cap_q;
	int error_cnt = 0;
	int total_checks = 0;
	always #5 clock_i = ~clock_i;
	osc_status_regs #(.DW(16)) osc_status_regs_inst (.clock_i(clock_i),
		.rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .sample_valid_i(sv), .i_data_i(id), .q_data_i(qd),
		.burst_strobe_out_i(bs), .frame_strobe_out_i(fs), .sync_i(sy),
		.overflow_i(ov), .cap_i_o(cap_i), .cap_q_o(cap_q), .int_n_o(int_n),
		.ovf_pin_n_o(ovf_n), .pulse_out_n_o(pls_n), .standby_o(stby));
	osc_src_model osc_src_model_inst (.clock_i(clock_i), .sample_valid_o(sv),
		.i_data_o(id), .q_data_o(qd), .burst_strobe_o(bs),
		.frame_strobe_o(fs), .sync_o(sy), .overflow_o(ov));
	// ========================================
	// bus tasks and checks
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wrr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask : wrr
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1;
		chk({8'h00, rdata}, {8'h00, e});
	endtask : rdc
	task automatic nxt();
		@(posedge clock_i);
		#1;
	endtask : nxt
	task print_verdict;
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end
	// ========================================
	// test sequence
	initial begin
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		rdc(4'h9, 8'h00);
		rdc(4'hb, 8'h00);
		wrr(4'h9, 8'h01);
		rdc(4'h9, 8'h01);
		chk(16'(int_n), 16'h0001);
		osc_src_model_inst.sample(16'h1234);
		rdc(4'h9, 8'h00);
		chk(cap_i, 16'h1234);
		chk(cap_q, 16'hedcb);
		osc_src_model_inst.sample(16'h00ab);
		rdc(4'h9, 8'h02);
		wrr(4'h9, 8'h02);
		rdc(4'h9, 8'h02);
		wrr(4'h9, 8'h03);
		rdc(4'h9, 8'h03);
		wrr(4'h9, 8'h01);
		rdc(4'h9, 8'h01);
		wrr(4'h9, 8'h05);
		#1;
		chk(16'(int_n), 16'h0001);
		osc_src_model_inst.sample(16'h0f0f);
		#1;
		chk(16'(int_n), 16'h0000);
		rdc(4'h9, 8'h04);
		wrr(4'h9, 8'h00);
		fork
			wrr(4'h9, 8'h01);
			osc_src_model_inst.sample(16'h0055);
		join
		rdc(4'h9, 8'h03);
		osc_src_model_inst.sample(16'h0066);
		rdc(4'h9, 8'h03);
		chk(cap_i, 16'h0f0f);
		wrr(4'h9, 8'h00);
		wrr(4'h9, 8'h01);
		osc_src_model_inst.sample(16'h0088);
		rdc(4'h9, 8'h00);
		chk(cap_i, 16'h0088);
		wrr(4'h9, 8'h20);
		osc_src_model_inst.ovf();
		nxt();
		chk(16'(ovf_n), 16'h0000);
		rdc(4'h9, 8'h60);
		wrr(4'h9, 8'h60);
		rdc(4'h9, 8'h60);
		wrr(4'h9, 8'h20);
		rdc(4'h9, 8'h20);
		chk(16'(ovf_n), 16'h0001);
		wrr(4'h9, 8'h10);
		osc_src_model_inst.ovf();
		nxt();
		chk(16'(ovf_n), 16'h0001);
		rdc(4'h9, 8'h10);
		wrr(4'h9, 8'h30);
		osc_src_model_inst.ovf();
		#1;
		chk(16'(ovf_n), 16'h0000);
		nxt();
		chk(16'(ovf_n), 16'h0001);
		rdc(4'h9, 8'h70);
		wrr(4'ha, 8'h5a);
		#1;
		chk(16'(pls_n), 16'h0000);
		nxt();
		chk(16'(pls_n), 16'h0001);
		rdc(4'ha, 8'h00);
		rdc(4'h3, 8'h00);
		wrr(4'h9, 8'h81);
		#1;
		chk(16'(stby), 16'h0001);
		osc_src_model_inst.sample(16'h0077);
		rdc(4'h9, 8'h81);
		wrr(4'h9, 8'h00);
		osc_src_model_inst.sync_fall();
		osc_src_model_inst.sync_fall();
		rdc(4'h9, 8'h00);
		print_verdict();
	end
endmodule : output_status_capture_regs_test
